// File: hw/aswc_cfg.svh
// timing and encoding constants for the select-ended static memory write
`ifndef ASWC_CFG_SVH
`define ASWC_CFG_SVH

// controller clock period
`define ASWC_CLK_PERIOD_NS      5

// slowest grade minima of the select-ended write
`define ASWC_SELECT_TO_WRITE_END_TIME_NS   20
`define ASWC_ADDRESS_TO_WRITE_END_TIME_NS  20
`define ASWC_DATA_TO_WRITE_END_TIME_NS     11
`define ASWC_WRITE_CYCLE_TIME_NS           35

// least times round up to whole cycles
`define ASWC_CEIL_CYC(t) (((t) + `ASWC_CLK_PERIOD_NS - 1) / `ASWC_CLK_PERIOD_NS)

`define ASWC_SELECT_CYC   `ASWC_CEIL_CYC(`ASWC_SELECT_TO_WRITE_END_TIME_NS)
`define ASWC_ADDRESS_CYC  `ASWC_CEIL_CYC(`ASWC_ADDRESS_TO_WRITE_END_TIME_NS)
`define ASWC_DATA_CYC     `ASWC_CEIL_CYC(`ASWC_DATA_TO_WRITE_END_TIME_NS)
`define ASWC_CYCLE_CYC    `ASWC_CEIL_CYC(`ASWC_WRITE_CYCLE_TIME_NS)

// counter width
`define ASWC_CNT_W        4

// pin levels
`define ASWC_STROBE_IDLE  1'h1
`define ASWC_STROBE_ON    1'h0

// timer expiry count
`define ASWC_TMR_LAST     4'h1

`endif

// File: hw/aswc_ctrl.sv
// host controller issuing select-ended writes to an asynchronous memory
//
// Functional notes
// - select held low for the select minimum
// - address valid the address minimum before end
// - data stable the data minimum before end
// - cycle timed from address valid to change
// - never drive data while memory might drive
`timescale 1ns/100ps
`include "aswc_cfg.svh"

module aswc_ctrl #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 4
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // user write request
    input  wire logic              wr_req,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    output logic                   wr_ready,
    output logic                   wr_done,
    // memory pins
    output logic [ADDR_W-1:0]      address_in,
    output logic                   chip_select_n,
    output logic                   write_strobe_n,
    output logic                   output_gate_n,
    input  wire logic [DATA_W-1:0] data_io_in,
    output logic [DATA_W-1:0]      data_io_out,
    output logic                   data_io_oe
);

    ////////////////////////////////////////////////////////////////////
    // derived cycle counts

    localparam aswc_pkg::aswc_cnt_type SELECT_CYC =
        `ASWC_CNT_W'(`ASWC_SELECT_CYC);
    localparam aswc_pkg::aswc_cnt_type DATA_CYC =
        `ASWC_CNT_W'(`ASWC_DATA_CYC);
    localparam aswc_pkg::aswc_cnt_type ADDRESS_CYC =
        `ASWC_CNT_W'(`ASWC_ADDRESS_CYC);
    localparam aswc_pkg::aswc_cnt_type CYCLE_CYC =
        `ASWC_CNT_W'(`ASWC_CYCLE_CYC);

    // the select window must cover every end-of-write minimum
    function automatic aswc_pkg::aswc_cnt_type max_cnt(
        input aswc_pkg::aswc_cnt_type a,
        input aswc_pkg::aswc_cnt_type b
    );
        max_cnt = (a > b) ? a : b;
    endfunction

    // data and address start one setup cycle before select falls
    localparam aswc_pkg::aswc_cnt_type WINDOW_CYC =
        max_cnt(SELECT_CYC, max_cnt(DATA_CYC, ADDRESS_CYC));

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        aswc_pkg::aswc_state_type fsm;
        aswc_pkg::aswc_cnt_type   age;
        logic [ADDR_W-1:0]        addr;
        logic [DATA_W-1:0]        data;
        logic                     cs_n;
        logic                     we_n;
        logic                     oe_n;
        logic                     drive;
        logic                     ready;
        logic                     done;
    } aswc_ctrl_state_type;

    aswc_ctrl_state_type state_ff;
    aswc_ctrl_state_type nxt_state;

    aswc_tmr_if tmr ();

    aswc_timer u_timer (
        .clock (clock),
        .rst   (rst),
        .tmr   (tmr)
    );

    ////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        nxt_state = state_ff;
        nxt_state.done = 1'h0;
        tmr.start = 1'h0;
        tmr.load = WINDOW_CYC;
        // address age since it last became valid
        if (state_ff.age != '1) begin
            nxt_state.age = state_ff.age + `ASWC_CNT_W'(1);
        end
        unique case (state_ff.fsm)
            aswc_pkg::ASWC_IDLE: begin
                if (wr_req && state_ff.ready) begin
                    nxt_state.fsm = aswc_pkg::ASWC_SETUP;
                    nxt_state.addr = wr_addr;
                    nxt_state.data = wr_data;
                    nxt_state.age = '0;
                    nxt_state.we_n = `ASWC_STROBE_ON;
                    nxt_state.drive = 1'h1;
                    nxt_state.ready = 1'h0;
                end
            end
            aswc_pkg::ASWC_SETUP: begin
                // strobe already low, select follows
                nxt_state.fsm = aswc_pkg::ASWC_SELECT;
                nxt_state.cs_n = `ASWC_STROBE_ON;
                tmr.start = 1'h1;
            end
            aswc_pkg::ASWC_SELECT: begin
                if (tmr.expire) begin
                    nxt_state.fsm = aswc_pkg::ASWC_RELEASE;
                    nxt_state.cs_n = `ASWC_STROBE_IDLE;
                end
            end
            aswc_pkg::ASWC_RELEASE: begin
                // strobe rises after select, data still held
                nxt_state.fsm = aswc_pkg::ASWC_RECOVER;
                nxt_state.we_n = `ASWC_STROBE_IDLE;
            end
            aswc_pkg::ASWC_RECOVER: begin
                nxt_state.drive = 1'h0;
                // address held until the whole cycle time has passed
                if (state_ff.age >= CYCLE_CYC - `ASWC_CNT_W'(2)) begin
                    nxt_state.fsm = aswc_pkg::ASWC_IDLE;
                    nxt_state.ready = 1'h1;
                    nxt_state.done = 1'h1;
                end
            end
            default: begin
                nxt_state.fsm = aswc_pkg::ASWC_IDLE;
                nxt_state.cs_n = `ASWC_STROBE_IDLE;
                nxt_state.we_n = `ASWC_STROBE_IDLE;
                nxt_state.drive = 1'h0;
                nxt_state.ready = 1'h1;
            end
        endcase
        // memory output gate never opened by this controller
        nxt_state.oe_n = `ASWC_STROBE_IDLE;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff.fsm <= aswc_pkg::ASWC_IDLE;
            state_ff.age <= '1;
            state_ff.addr <= '0;
            state_ff.data <= '0;
            state_ff.cs_n <= `ASWC_STROBE_IDLE;
            state_ff.we_n <= `ASWC_STROBE_IDLE;
            state_ff.oe_n <= `ASWC_STROBE_IDLE;
            state_ff.drive <= 1'h0;
            state_ff.ready <= 1'h1;
            state_ff.done <= 1'h0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from the state register

    assign wr_ready = state_ff.ready;
    assign wr_done = state_ff.done;
    assign address_in = state_ff.addr;
    assign chip_select_n = state_ff.cs_n;
    assign write_strobe_n = state_ff.we_n;
    assign output_gate_n = state_ff.oe_n;
    assign data_io_out = state_ff.data;
    assign data_io_oe = state_ff.drive;

    // read data not used by a write-only controller
    logic unused_rd;
    assign unused_rd = ^data_io_in;

endmodule

// File: hw/aswc_pkg.sv
// types of the select-ended static memory write controller
`include "aswc_cfg.svh"

package aswc_pkg;

    // gray codes along idle, setup, select, release, recover
    typedef enum logic [2:0] {
        ASWC_IDLE    = 3'h0,
        ASWC_SETUP   = 3'h1,
        ASWC_SELECT  = 3'h3,
        ASWC_RELEASE = 3'h2,
        ASWC_RECOVER = 3'h6
    } aswc_state_type;

    typedef logic [`ASWC_CNT_W-1:0] aswc_cnt_type;

endpackage

// File: hw/aswc_timer.sv
// down counter that flags the last cycle of a loaded interval
`timescale 1ns/100ps
`include "aswc_cfg.svh"

module aswc_timer (
    // clock and reset
    input  wire logic     clock,
    input  wire logic     rst,
    // control
    aswc_tmr_if.timer     tmr
);

    typedef struct packed {
        aswc_pkg::aswc_cnt_type cnt;
    } aswc_tmr_state_type;

    aswc_tmr_state_type state_ff;
    aswc_tmr_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (tmr.start) begin
            nxt_state.cnt = tmr.load;
        end else if (state_ff.cnt != '0) begin
            nxt_state.cnt = state_ff.cnt - `ASWC_CNT_W'(1);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign tmr.expire = (state_ff.cnt == `ASWC_TMR_LAST);

endmodule

// File: hw/aswc_tmr_if.sv
// interval timer handshake between controller and timer
`timescale 1ns/100ps

interface aswc_tmr_if;
    logic                 start;
    aswc_pkg::aswc_cnt_type load;
    logic                 expire;

    modport ctrl  (output start, output load, input expire);
    modport timer (input start, input load, output expire);
endinterface

// File: verification/aswc_ctrl_asserts.sv
// pin timing assertions for the select-ended write controller
`timescale 1ns/100ps

module aswc_ctrl_asserts #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 4
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              rst,
    // user side
    input wire logic              wr_req,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic              wr_ready,
    input wire logic              wr_done,
    // memory side
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic              chip_select_n,
    input wire logic              write_strobe_n,
    input wire logic              output_gate_n,
    input wire logic [DATA_W-1:0] data_io_out,
    input wire logic              data_io_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    chk_take_value: assert property (wr_req && wr_ready |=>
        address_in == $past(wr_addr) && data_io_out == $past(wr_data))
        else $error("address or data not loaded at take");
    chk_done_latency: assert property (wr_req && wr_ready |->
        ##2 !wr_ready [*6] ##1 (wr_ready && wr_done))
        else $error("write cycle length wrong");
    chk_select_width: assert property ($fell(chip_select_n) |->
        !chip_select_n [*4] ##1 chip_select_n)
        else $error("select low time wrong");
    chk_select_after: assert property ($fell(chip_select_n) |->
        !$past(write_strobe_n))
        else $error("select fell before write strobe");
    chk_select_first: assert property ($rose(chip_select_n) |->
        !write_strobe_n ##1 write_strobe_n)
        else $error("select did not rise before write strobe");
    chk_addr_stable: assert property ($fell(write_strobe_n) |=>
        $stable(address_in) [*6])
        else $error("address moved during write");
    chk_data_stable: assert property ($fell(write_strobe_n) |=>
        (data_io_oe && $stable(data_io_out)) [*5])
        else $error("write data not held");
    chk_gate_high: assert property (output_gate_n)
        else $error("output gate driven low");
    chk_done_pulse: assert property (wr_done |=> !wr_done)
        else $error("done pulse longer than one cycle");
    chk_data_release: assert property ($rose(write_strobe_n) |=>
        !data_io_oe)
        else $error("data still driven after write strobe rose");

    cover property (wr_req && wr_ready);
    cover property (wr_done && wr_req);
    cover property ($rose(chip_select_n));
endmodule

bind aswc_ctrl aswc_ctrl_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
    .clock, .rst, .wr_req, .wr_addr, .wr_data, .wr_ready, .wr_done,
    .address_in, .chip_select_n, .write_strobe_n, .output_gate_n,
    .data_io_out, .data_io_oe);

// File: verification/aswc_mem_model.sv
// behavioural model of the asynchronous 4-bit static memory
`timescale 1ns/100ps

module aswc_mem_model #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 4
) (
    // memory pins
    input  wire logic [ADDR_W-1:0] address_in,
    input  wire logic              chip_select_n,
    input  wire logic              write_strobe_n,
    input  wire logic              output_gate_n,
    input  wire logic [DATA_W-1:0] data_io,
    // read drive
    output logic [DATA_W-1:0]      q,
    output logic                   q_en
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];

    // write lands when the first strobe of the overlap rises
    always @(posedge chip_select_n) begin
        if (!write_strobe_n) mem[address_in] = data_io;
    end
    always @(posedge write_strobe_n) begin
        if (!chip_select_n) mem[address_in] = data_io;
    end
    // any low write strobe keeps the pins floating
    assign q_en = !chip_select_n && !output_gate_n
        && write_strobe_n;
    always @* q = mem.exists(address_in) ? mem[address_in] : ~data_io;
endmodule

// File: verification/async_sram_enable_write_cycle_tb_top.sv
// self-checking bench for the select-ended write controller
`timescale 1ns/100ps

module async_sram_enable_write_cycle_tb_top;
    logic        clock, rst, wr_req, wr_ready, wr_done, q_en;
    logic        chip_select_n, write_strobe_n, output_gate_n, data_io_oe;
    logic [17:0] wr_addr, address_in, a;
    logic [3:0]  wr_data, data_io_out, q, d;
    logic [15:0] seed;
    int          n_mismatch, tests_run, cycles;
    // undriven bus shows the inverse of the last driven value
    wire  [3:0]  data_io = data_io_oe ? data_io_out
                         : (q_en ? q : ~data_io_out);

    aswc_ctrl i_dut (
        .clock, .rst, .wr_req, .wr_addr, .wr_data, .wr_ready, .wr_done,
        .address_in, .chip_select_n, .write_strobe_n, .output_gate_n,
        .data_io_in(data_io), .data_io_out, .data_io_oe);
    aswc_mem_model i_mem (
        .address_in, .chip_select_n, .write_strobe_n, .output_gate_n,
        .data_io, .q, .q_en);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // request held to the taking edge, then refused junk while busy
    task automatic do_write(input logic [17:0] ad, input logic [3:0] dd);
        int n;
        n = 0;
        check(wr_ready, 1'h1);
        wr_req  = 1'h1;
        wr_addr = ad;
        wr_data = dd;
        @(posedge clock);
        #1;
        wr_addr = ~ad;
        wr_data = ~dd;
        while (wr_done !== 1'h1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(n, 7);
        check(i_mem.mem[ad], dd);
        check(address_in, ad);
        check(data_io_oe, 1'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        rst = 1'h1;
        wr_req = 1'h0;
        wr_addr = 18'h0;
        wr_data = 4'h0;
        seed = 16'h5064;
        repeat (10) @(posedge clock);
        #1;
        rst = 1'h0;
        check({chip_select_n, write_strobe_n, output_gate_n, data_io_oe,
               wr_ready, wr_done}, 6'h3A);
        $display("test reset values done");
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            a = {seed[15:14], lfsr(seed)};
            d = seed[3:0];
            if (i < 2) begin
                a = i ? 18'h3FFFF : 18'h0;
                d = i ? 4'hF : 4'h0;
            end
            do_write(a, d);
        end
        wr_req = 1'h0;
        repeat (2) @(posedge clock);
        check(i_mem.mem[18'h3FFFF], 4'hF);
        $display("test random back to back writes done");
        // reset lands while select and strobe are low
        #1;
        wr_req  = 1'h1;
        wr_addr = 18'h2A5A5;
        wr_data = 4'h5;
        @(posedge clock);
        #1;
        wr_req = 1'h0;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'h1;
        @(posedge clock);
        #1;
        rst = 1'h0;
        check({chip_select_n, write_strobe_n, output_gate_n, data_io_oe,
               wr_ready, wr_done}, 6'h3A);
        do_write(18'h2A5A5, 4'h6);
        $display("test reset in mid write done");
        print_verdict();
    end
endmodule
